/* design/dbs_pkg.sv */
// Shared constants, types and helper functions for the DDR burst SRAM port and its controller.
// Overview of operation
// - Address held stable, captured at true rise.
// - Address ignored when deselected or mid-burst.
// - Each transaction spans two clock periods.
// - Non-plus x18/x36 take random burst start.
// - Controller pulls load low to start cycles.
// - Direction high reads, low writes, at rise.
// - Only enabled bytes stored, per data edge.
// - Control on true rise, data both rises.
// - Complement clock is true clock inverted.
// - Output words timed from output clock pair.
// - Tied-high output clocks select input clocks.
// - Plus parts always time outputs from input.
// - Low bypass input only reported as delay loop bypassed.
// - Termination input selects range or disable.
// - Data lines used follow the organisation.
// - Echo clocks run free, matched to data.
// - Read valid flag aligned with echo clocks; valid here follows true rise even when output clocks time the words.
// - x9 bursts always start at word zero.
// - Read words at complement t+2, true t+3.
// - Write words at true and complement t+1.
// - Valid leads read data by half cycle.
package dbs_pkg;
  localparam int CORE_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CORE_PERIOD_NS);
  localparam logic [2:0] PH_LAST  = 3'(2 * LINK_HALF_CYC - 1);
  localparam logic [2:0] PH_CMD   = 3'h6;
  localparam logic [2:0] PH_WORD1 = 3'h2;
  localparam logic [2:0] GAP_NORMAL     = 3'h2;
  localparam logic [2:0] GAP_AFTER_READ = 3'h4;
  localparam int ADDR_W = 8;
  localparam int DEPTH  = 1 << ADDR_W;
  localparam int DATA_W = 36;
  localparam int BYTES  = 4;
  localparam int BYTE_W = 9;
  localparam int SYNC_DEV_W  = 9 + ADDR_W + BYTES + DATA_W;
  localparam int SYNC_HOST_W = 3 + DATA_W;

  typedef enum logic [1:0] {ORG_X9, ORG_X18, ORG_X36} dbs_org_e;
  typedef enum logic [1:0] {ODT_OFF, ODT_LOW, ODT_HIGH} dbs_odt_e;

  typedef struct packed {
    logic              vld;
    logic              rd;
    logic [ADDR_W-1:0] addr;
  } dbs_stage_s;

  function automatic logic [BYTES-1:0] byteMask(input dbs_org_e org);
    case (org)
      ORG_X9:  byteMask = 4'h1;
      ORG_X18: byteMask = 4'h3;
      default: byteMask = 4'hF;
    endcase
  endfunction : byteMask

  function automatic logic [DATA_W-1:0] lineMask(input dbs_org_e org);
    logic [BYTES-1:0] b;
    b = byteMask(org);
    lineMask = '0;
    for (int i = 0; i < BYTES; i++)
    begin
      lineMask[i*BYTE_W +: BYTE_W] = {BYTE_W{b[i]}};
    end
  endfunction : lineMask

  function automatic logic [DATA_W-1:0] mergeBytes(input logic [DATA_W-1:0] old,
                                                   input logic [DATA_W-1:0] nw,
                                                   input logic [BYTES-1:0]  bwN,
                                                   input dbs_org_e          org);
    logic [BYTES-1:0] en;
    en = byteMask(org) & ~bwN;
    mergeBytes = old;
    for (int i = 0; i < BYTES; i++)
    begin
      if (en[i])
      begin
        mergeBytes[i*BYTE_W +: BYTE_W] = nw[i*BYTE_W +: BYTE_W];
      end
    end
  endfunction : mergeBytes

  function automatic logic [ADDR_W-1:0] startAddr(input logic [ADDR_W-1:0] a,
                                                  input dbs_org_e          org,
                                                  input logic              plusGen);
    if (!plusGen && org != ORG_X9)
    begin
      startAddr = a;
    end
    else
    begin
      startAddr = {a[ADDR_W-1:2], 2'h0};
    end
  endfunction : startAddr
endpackage : dbs_pkg

/* design/dbs_link_if.sv */
// Link between the burst SRAM port and its controller, with the shared data bus resolved.
`timescale 1ns/1ps
interface dbs_link_if;
  logic                        kTrue;
  logic                        kBar;
  logic                        outClkTrue;
  logic                        outClkBar;
  logic [dbs_pkg::ADDR_W-1:0]  syncAddr;
  logic                        cycleDefineN;
  logic                        readNotWrite;
  logic [dbs_pkg::BYTES-1:0]   byteWriteN;
  logic [dbs_pkg::DATA_W-1:0]  dqHostOut;
  logic                        dqHostOe;
  logic [dbs_pkg::DATA_W-1:0]  dqDevOut;
  logic                        dqDevOe;
  wire  [dbs_pkg::DATA_W-1:0]  dq;
  logic                        echoStrobeTrue;
  logic                        echoStrobeBar;
  logic                        readValidFlag;
  logic                        delayLoopBypassN;
  logic                        termRangeLevel;
  logic                        termRangeFloat;

  // An idle bus reads as zero, like a pulled-down line, so neither end samples unknowns.
  assign dq = dqDevOe ? dqDevOut : (dqHostOe ? dqHostOut : '0);

  modport device (input kTrue, kBar, outClkTrue, outClkBar, syncAddr, cycleDefineN,
                  readNotWrite, byteWriteN, dq, delayLoopBypassN, termRangeLevel,
                  termRangeFloat,
                  output dqDevOut, dqDevOe, echoStrobeTrue, echoStrobeBar, readValidFlag);
  modport host (output kTrue, kBar, outClkTrue, outClkBar, syncAddr, cycleDefineN,
                readNotWrite, byteWriteN, dqHostOut, dqHostOe, delayLoopBypassN,
                termRangeLevel, termRangeFloat,
                input dq, echoStrobeTrue, echoStrobeBar, readValidFlag);
endinterface : dbs_link_if

/* design/dbs_sync2.sv */
// Two-flop synchroniser for a bundle of levels arriving from outside the clock domain.
`timescale 1ns/1ps
module dbs_sync2 #(
  parameter int W = 1
) (
  input  logic         core_clk,
  input  logic         rstn,
  input  logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dbs_sync_s;

  dbs_sync_s q;
  dbs_sync_s d;

  always_comb
  begin
    d    = q;
    d.s1 = din;
    d.s2 = q.s1;
    if (!rstn)
    begin
      d = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    q <= d;
  end

  assign dout = q.s2;
endmodule : dbs_sync2

/* design/dbs_sram_dev.sv */
// Memory-side end of the DDR burst SRAM port: command capture, array, read pipeline, echo.
`timescale 1ns/1ps
module dbs_sram_dev (
  input  logic              core_clk,
  input  logic              rstn,
  dbs_link_if.device        link,
  input  dbs_pkg::dbs_org_e orgSel,
  input  logic              plusGen,
  input  logic              termOption,
  output logic              dllBypassed,
  output dbs_pkg::dbs_odt_e odtMode
);
  typedef struct packed {
    logic [dbs_pkg::DEPTH-1:0][dbs_pkg::DATA_W-1:0] mem;
    logic                                           kPrev;
    logic                                           kbPrev;
    logic                                           cPrev;
    logic                                           cbPrev;
    logic                                           busy;
    dbs_pkg::dbs_stage_s                            s1;
    dbs_pkg::dbs_stage_s                            s2;
    logic                                           pend0;
    logic                                           pend1;
    logic [dbs_pkg::ADDR_W-1:0]                     pendAddr;
    logic                                           rdValid;
    logic [dbs_pkg::DATA_W-1:0]                     dqOut;
    logic                                           dqOe;
    logic                                           echoT;
    logic                                           echoB;
    logic                                           dllByp;
    dbs_pkg::dbs_odt_e                              termination_range_sel;
  } dbs_dev_s;

  dbs_dev_s q;
  dbs_dev_s d;

  logic [dbs_pkg::SYNC_DEV_W-1:0] pinsRaw;
  logic [dbs_pkg::SYNC_DEV_W-1:0] pinsSync;
  logic                           kS;
  logic                           kbS;
  logic                           cS;
  logic                           cbS;
  logic                           ldNS;
  logic                           rnwS;
  logic [dbs_pkg::ADDR_W-1:0]     addrS;
  logic [dbs_pkg::BYTES-1:0]      bwNS;
  logic [dbs_pkg::DATA_W-1:0]     dqS;
  logic                           dllNS;
  logic                           termLvlS;
  logic                           termFltS;
  logic                           kRise;
  logic                           kbRise;
  logic                           useK;
  logic                           refRise;
  logic                           refBarRise;
  logic                           refLevel;
  logic                           accept;
  logic [dbs_pkg::DATA_W-1:0]     lines;

  assign pinsRaw = {link.kTrue, link.kBar, link.outClkTrue, link.outClkBar,
                    link.cycleDefineN, link.readNotWrite, link.syncAddr, link.byteWriteN,
                    link.dq, link.delayLoopBypassN, link.termRangeLevel,
                    link.termRangeFloat};

  dbs_sync2 #(
    .W (dbs_pkg::SYNC_DEV_W)
  ) pinSync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .din      (pinsRaw),
    .dout     (pinsSync)
  );

  assign {kS, kbS, cS, cbS, ldNS, rnwS, addrS, bwNS, dqS, dllNS, termLvlS, termFltS} =
         pinsSync;

  // Edges are found on the synchronised copies, so every sampled pin lines up with them.
  assign kRise  = kS && !q.kPrev;
  assign kbRise = kbS && !q.kbPrev;

  // Plus parts, or output clocks held high, fall back to the input pair.
  assign useK       = plusGen || (cS && cbS);
  // Output clock pair times the words when it toggles.
  assign refRise    = useK ? kRise : (cS && !q.cPrev);
  assign refBarRise = useK ? kbRise : (cbS && !q.cbPrev);
  assign refLevel   = useK ? kS : cS;

  // A load is taken only when selected and no burst is still running.
  assign accept = !ldNS && !q.busy;
  // Unused lines of narrow organisations read back as zero.
  assign lines  = dbs_pkg::lineMask(orgSel);

  always_comb
  begin
    d        = q;
    d.kPrev  = kS;
    d.kbPrev = kbS;
    d.cPrev  = cS;
    d.cbPrev = cbS;

    if (kRise)
    begin
      // First write word for the command loaded one true period ago.
      if (q.s1.vld && !q.s1.rd)
      begin
        d.mem[q.s1.addr] = dbs_pkg::mergeBytes(q.mem[q.s1.addr], dqS, bwNS, orgSel);
      end
      // Valid rises half a period ahead of the first read word.
      d.rdValid = q.s2.vld && q.s2.rd;
      if (q.s2.vld && q.s2.rd)
      begin
        d.pend0    = 1'b1;
        d.pendAddr = q.s2.addr;
      end
      d.s2 = q.s1;
      // Address, direction and start position are taken on this edge only.
      d.s1.vld  = accept;
      d.s1.rd   = rnwS;
      // Burst start follows organisation and generation.
      d.s1.addr = dbs_pkg::startAddr(addrS, orgSel, plusGen);
      d.busy    = accept;
    end

    // Second write word arrives on the complement edge of the same period.
    if (kbRise && q.s2.vld && !q.s2.rd)
    begin
      d.mem[q.s2.addr ^ dbs_pkg::ADDR_W'(1)] =
          dbs_pkg::mergeBytes(q.mem[q.s2.addr ^ dbs_pkg::ADDR_W'(1)], dqS, bwNS, orgSel);
    end

    // First read word two and a half periods after the command.
    if (refBarRise)
    begin
      if (q.pend0)
      begin
        d.dqOut = q.mem[q.pendAddr] & lines;
        d.dqOe  = 1'b1;
        d.pend0 = 1'b0;
        d.pend1 = 1'b1;
      end
      else if (!q.pend1)
      begin
        // Bus handed back on the first complement edge with no word due.
        d.dqOe = 1'b0;
      end
    end

    // Second read word on the following true edge.
    if (refRise && q.pend1)
    begin
      d.dqOut = q.mem[q.pendAddr ^ dbs_pkg::ADDR_W'(1)] & lines;
      d.pend1 = 1'b0;
    end

    // Echo pair follows the timing reference without pause.
    d.echoT = refLevel;
    d.echoB = !refLevel;

    // No delay loop is modelled; the bypass level is only reported.
    d.dllByp = !dllNS;

    // Termination is also turned off while this end drives the bus.
    if (q.dqOe)
    begin
      d.termination_range_sel = dbs_pkg::ODT_OFF;
    end
    else if (termFltS)
    begin
      d.termination_range_sel = termOption ? dbs_pkg::ODT_OFF : dbs_pkg::ODT_HIGH;
    end
    else if (termLvlS)
    begin
      d.termination_range_sel = dbs_pkg::ODT_HIGH;
    end
    else
    begin
      d.termination_range_sel = termOption ? dbs_pkg::ODT_OFF : dbs_pkg::ODT_LOW;
    end

    if (!rstn)
    begin
      d       = '0;
      d.echoB = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    q <= d;
  end

  assign link.dqDevOut       = q.dqOut;
  assign link.dqDevOe        = q.dqOe;
  assign link.echoStrobeTrue = q.echoT;
  assign link.echoStrobeBar  = q.echoB;
  assign link.readValidFlag  = q.rdValid;
  assign dllBypassed         = q.dllByp;
  assign odtMode             = q.termination_range_sel;
endmodule : dbs_sram_dev

/* design/dbs_sram_host.sv */
// Controller end of the DDR burst SRAM port: clock generation, command launch, read capture.
`timescale 1ns/1ps
module dbs_sram_host (
  input  logic                       core_clk,
  input  logic                       rstn,
  dbs_link_if.host                   link,
  input  logic                       cmdValid,
  input  logic                       cmdWrite,
  input  logic [dbs_pkg::ADDR_W-1:0] cmdAddr,
  input  logic [dbs_pkg::DATA_W-1:0] cmdWord0,
  input  logic [dbs_pkg::DATA_W-1:0] cmdWord1,
  input  logic [dbs_pkg::BYTES-1:0]  cmdByteWriteN0,
  input  logic [dbs_pkg::BYTES-1:0]  cmdByteWriteN1,
  input  logic                       bypassReq,
  input  logic                       termLevel,
  input  logic                       termFloat,
  output logic                       cmdReady,
  output logic                       rdValid,
  output logic [dbs_pkg::DATA_W-1:0] rdWord0,
  output logic [dbs_pkg::DATA_W-1:0] rdWord1
);
  typedef enum logic {H_IDLE, H_HOLD} dbs_host_e;

  typedef struct packed {
    logic [2:0]                 phase;
    logic                       kT;
    logic                       kB;
    dbs_host_e                  st;
    logic [2:0]                 gap;
    logic                       ready;
    logic                       hWrite;
    logic [dbs_pkg::ADDR_W-1:0] hAddr;
    logic [dbs_pkg::DATA_W-1:0] hW0;
    logic [dbs_pkg::DATA_W-1:0] hW1;
    logic [dbs_pkg::BYTES-1:0]  hBw0;
    logic [dbs_pkg::BYTES-1:0]  hBw1;
    logic                       ldN;
    logic                       rnw;
    logic [dbs_pkg::ADDR_W-1:0] addrOut;
    logic [dbs_pkg::BYTES-1:0]  bwOut;
    logic [dbs_pkg::DATA_W-1:0] dqOut;
    logic                       dqOe;
    logic                       wrPend;
    logic [1:0]                 wrStage;
    logic [dbs_pkg::DATA_W-1:0] wd0;
    logic [dbs_pkg::DATA_W-1:0] wd1;
    logic [dbs_pkg::BYTES-1:0]  wbw0;
    logic [dbs_pkg::BYTES-1:0]  wbw1;
    logic                       etPrev;
    logic                       ebPrev;
    logic                       gotW0;
    logic [dbs_pkg::DATA_W-1:0] rdW0;
    logic [dbs_pkg::DATA_W-1:0] rdW1;
    logic                       rdV;
    logic                       dllN;
    logic                       termL;
    logic                       termF;
  } dbs_hst_s;

  dbs_hst_s q;
  dbs_hst_s d;

  logic [dbs_pkg::SYNC_HOST_W-1:0] inRaw;
  logic [dbs_pkg::SYNC_HOST_W-1:0] inSync;
  logic                            etS;
  logic                            ebS;
  logic                            vS;
  logic [dbs_pkg::DATA_W-1:0]      dqS;
  logic [2:0]                      nextPhase;

  assign inRaw = {link.echoStrobeTrue, link.echoStrobeBar, link.readValidFlag, link.dq};

  dbs_sync2 #(
    .W (dbs_pkg::SYNC_HOST_W)
  ) echoSync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .din      (inRaw),
    .dout     (inSync)
  );

  assign {etS, ebS, vS, dqS} = inSync;
  assign nextPhase = (q.phase == dbs_pkg::PH_LAST) ? 3'h0 : q.phase + 3'h1;

  always_comb
  begin
    d       = q;
    d.phase = nextPhase;
    // Complement clock is the exact inverse of the true clock.
    d.kT    = nextPhase < 3'(dbs_pkg::LINK_HALF_CYC);
    d.kB    = !d.kT;
    d.rdV   = 1'b0;
    d.dllN  = !bypassReq;
    d.termL = termLevel;
    d.termF = termFloat;

    if (q.ready && cmdValid)
    begin
      d.ready  = 1'b0;
      d.st     = H_HOLD;
      d.hWrite = cmdWrite;
      d.hAddr  = cmdAddr;
      d.hW0    = cmdWord0;
      d.hW1    = cmdWord1;
      d.hBw0   = cmdByteWriteN0;
      d.hBw1   = cmdByteWriteN1;
    end

    // Pins change late in the low phase, one core cycle before each true rise, so they are settled around it.
    if (q.phase == dbs_pkg::PH_CMD)
    begin
      d.ldN   = 1'b1;
      d.bwOut = '1;
      if (q.gap != 3'h0)
      begin
        d.gap = q.gap - 3'h1;
      end
      if (q.wrStage == 2'h2)
      begin
        d.dqOe    = 1'b0;
        d.wrStage = 2'h0;
      end
      // First write word sits across the true rise after the command.
      if (q.wrPend)
      begin
        d.dqOut   = q.wd0;
        d.bwOut   = q.wbw0;
        d.dqOe    = 1'b1;
        d.wrPend  = 1'b0;
        d.wrStage = 2'h1;
      end
      // One load per transaction, with a longer pause after reads.
      if (q.st == H_HOLD && q.gap <= 3'h1)
      begin
        d.ldN     = 1'b0;
        d.rnw     = !q.hWrite;
        d.addrOut = q.hAddr;
        d.gap     = q.hWrite ? dbs_pkg::GAP_NORMAL : dbs_pkg::GAP_AFTER_READ;
        d.wrPend  = q.hWrite;
        d.wd0     = q.hW0;
        d.wd1     = q.hW1;
        d.wbw0    = q.hBw0;
        d.wbw1    = q.hBw1;
        d.st      = H_IDLE;
        d.ready   = 1'b1;
      end
    end

    // Second write word sits across the complement rise.
    if (q.phase == dbs_pkg::PH_WORD1 && q.wrStage == 2'h1)
    begin
      d.dqOut   = q.wd1;
      d.bwOut   = q.wbw1;
      d.wrStage = 2'h2;
    end

    // The first read word is taken on a complement echo edge while the valid flag is up, the second on the next true echo edge.
    d.etPrev = etS;
    d.ebPrev = ebS;
    if (ebS && !q.ebPrev && vS)
    begin
      d.rdW0  = dqS;
      d.gotW0 = 1'b1;
    end
    if (etS && !q.etPrev && q.gotW0)
    begin
      d.rdW1  = dqS;
      d.rdV   = 1'b1;
      d.gotW0 = 1'b0;
    end

    if (!rstn)
    begin
      d       = '0;
      // Starting from the last phase gives the first true clock high time a full half period.
      d.phase = dbs_pkg::PH_LAST;
      d.kB    = 1'b1;
      d.ldN   = 1'b1;
      d.bwOut = '1;
      d.ready = 1'b1;
      d.dllN  = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    q <= d;
  end

  assign link.kTrue            = q.kT;
  assign link.kBar             = q.kB;
  // Output clocks are held high for good, so the input pair times read data.
  assign link.outClkTrue       = 1'b1;
  assign link.outClkBar        = 1'b1;
  assign link.syncAddr         = q.addrOut;
  assign link.cycleDefineN     = q.ldN;
  assign link.readNotWrite     = q.rnw;
  assign link.byteWriteN       = q.bwOut;
  assign link.dqHostOut        = q.dqOut;
  assign link.dqHostOe         = q.dqOe;
  assign link.delayLoopBypassN = q.dllN;
  assign link.termRangeLevel   = q.termL;
  assign link.termRangeFloat   = q.termF;
  assign cmdReady              = q.ready;
  assign rdValid               = q.rdV;
  assign rdWord0               = q.rdW0;
  assign rdWord1               = q.rdW1;
endmodule : dbs_sram_host

/* tb/dbs_link_asserts.sv */
// Checker for the link between the burst SRAM port and its controller.
`timescale 1ns/1ps
module dbs_link_asserts (
  input logic                       core_clk,
  input logic                       rstn,
  input logic                       kTrue,
  input logic                       kBar,
  input logic                       outClkTrue,
  input logic                       outClkBar,
  input logic [dbs_pkg::ADDR_W-1:0] syncAddr,
  input logic                       cycleDefineN,
  input logic                       readNotWrite,
  input logic                       dqHostOe,
  input logic                       dqDevOe,
  input logic                       echoStrobeTrue,
  input logic                       echoStrobeBar,
  input logic                       readValidFlag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_kbar_inverse; kBar != kTrue; endproperty
  a_kbar_inverse: assert property (p_kbar_inverse)
    else $error("complement clock not inverse of true clock");
  property p_link_period; $rose(kTrue) |-> kTrue[*4] ##1 !kTrue[*4] ##1 kTrue; endproperty
  a_link_period: assert property (p_link_period)
    else $error("true clock period or duty wrong");
  property p_outclk_high; outClkTrue && outClkBar; endproperty
  a_outclk_high: assert property (p_outclk_high)
    else $error("output clock pair not held high");
  property p_addr_stable;
    $rose(kTrue) && !cycleDefineN |->
      $stable(syncAddr) && $stable(readNotWrite) ##1 $stable(syncAddr) && !cycleDefineN;
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address or load moved around true clock rise");
  // The write words follow one link period after the load, for one period.
  property p_write_slot;
    $fell(cycleDefineN) && !readNotWrite |-> !dqHostOe[*8] ##1 dqHostOe[*8] ##1 !dqHostOe;
  endproperty
  a_write_slot: assert property (p_write_slot)
    else $error("write data slot misplaced");
  property p_read_latency;
    $fell(cycleDefineN) && readNotWrite |-> ##[18:28] $rose(readValidFlag);
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read valid not raised after read load");
  property p_valid_frame;
    $rose(readValidFlag) |-> ##4 $rose(dqDevOe) ##4 $fell(readValidFlag) ##4 $fell(dqDevOe);
  endproperty
  a_valid_frame: assert property (p_valid_frame)
    else $error("read valid not half a cycle ahead of read data");
  property p_valid_echo; $changed(readValidFlag) |-> $changed(echoStrobeTrue); endproperty
  a_valid_echo: assert property (p_valid_echo)
    else $error("read valid not aligned with echo clock");
  property p_echo_pair; echoStrobeBar != echoStrobeTrue; endproperty
  a_echo_pair: assert property (p_echo_pair)
    else $error("echo clocks not complementary");
  property p_echo_free; 1'b1 |-> ##[1:12] $changed(echoStrobeTrue); endproperty
  a_echo_free: assert property (p_echo_free)
    else $error("echo clock stopped");
  property p_no_clash; dqDevOe |-> !dqHostOe; endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the data bus");
  c_write: cover property ($fell(cycleDefineN) && !readNotWrite);
  c_read: cover property ($fell(cycleDefineN) && readNotWrite);
  c_valid: cover property ($rose(readValidFlag));
endmodule : dbs_link_asserts

/* tb/test_ddr_burst_sram_port.sv */
// Self-checking bench joining both ends of the burst SRAM port.
`timescale 1ns/1ps
module test_ddr_burst_sram_port;
  logic              core_clk = 1'b0;
  logic              rstn = 1'b0;
  logic              cmdValid = 1'b0;
  logic              cmdWrite = 1'b0;
  logic [7:0]        cmdAddr = 8'h00;
  logic [35:0]       cmdWord0 = 36'h0, cmdWord1 = 36'h0;
  logic [3:0]        cmdByteWriteN0 = 4'hF, cmdByteWriteN1 = 4'hF;
  logic              bypassReq = 1'b0, termLevel = 1'b0, termFloat = 1'b0;
  logic              plusGen = 1'b0, termOption = 1'b0;
  dbs_pkg::dbs_org_e orgSel = dbs_pkg::ORG_X36;
  logic              cmdReady, rdValid, dllBypassed;
  logic [35:0]       rdWord0, rdWord1;
  dbs_pkg::dbs_odt_e odtMode;
  logic [35:0]       mem [256];
  int                miscompares = 0;
  int                compares = 0;
  always #12.5 core_clk = ~core_clk;
  dbs_link_if dbs_link_if_i ();
  dbs_sram_dev dbs_sram_dev_i (.core_clk(core_clk), .rstn(rstn), .link(dbs_link_if_i),
    .orgSel(orgSel), .plusGen(plusGen), .termOption(termOption), .dllBypassed(dllBypassed),
    .odtMode(odtMode));
  dbs_sram_host dbs_sram_host_i (.core_clk(core_clk), .rstn(rstn), .link(dbs_link_if_i),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdWord0(cmdWord0),
    .cmdWord1(cmdWord1), .cmdByteWriteN0(cmdByteWriteN0), .cmdByteWriteN1(cmdByteWriteN1),
    .bypassReq(bypassReq), .termLevel(termLevel), .termFloat(termFloat), .cmdReady(cmdReady),
    .rdValid(rdValid), .rdWord0(rdWord0), .rdWord1(rdWord1));
  dbs_link_asserts dbs_link_asserts_i (.core_clk(core_clk), .rstn(rstn),
    .kTrue(dbs_link_if_i.kTrue), .kBar(dbs_link_if_i.kBar),
    .outClkTrue(dbs_link_if_i.outClkTrue), .outClkBar(dbs_link_if_i.outClkBar),
    .syncAddr(dbs_link_if_i.syncAddr), .cycleDefineN(dbs_link_if_i.cycleDefineN),
    .readNotWrite(dbs_link_if_i.readNotWrite), .dqHostOe(dbs_link_if_i.dqHostOe),
    .dqDevOe(dbs_link_if_i.dqDevOe), .echoStrobeTrue(dbs_link_if_i.echoStrobeTrue),
    .echoStrobeBar(dbs_link_if_i.echoStrobeBar), .readValidFlag(dbs_link_if_i.readValidFlag));

  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Only the non-plus wide parts may start a burst at any word.
  function automatic logic [7:0] startOf(input logic [7:0] a);
    return (!plusGen && orgSel != dbs_pkg::ORG_X9) ? a : {a[7:2], 2'h0};
  endfunction : startOf

  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw,
                                        input logic [3:0] bwN);
    logic [3:0] used;
    used = (orgSel == dbs_pkg::ORG_X9) ? 4'h1 : (orgSel == dbs_pkg::ORG_X18) ? 4'h3 : 4'hF;
    for (int i = 0; i < 4; i++)
    begin
      if (used[i] && !bwN[i])
      begin
        old[i*9 +: 9] = nw[i*9 +: 9];
      end
    end
    return old;
  endfunction : merge

  task automatic send(input logic wr, input logic [7:0] a, input logic [35:0] w0,
                      input logic [35:0] w1, input logic [3:0] b0, input logic [3:0] b1);
    int n;
    logic [7:0] s;
    s = startOf(a);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdAddr <= a;
    cmdWord0 <= w0;
    cmdWord1 <= w1;
    cmdByteWriteN0 <= b0;
    cmdByteWriteN1 <= b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (cmdReady !== 1'b1 && n < 400);
    check(36'(cmdReady), 36'h1);
    cmdValid <= 1'b0;
    if (wr)
    begin
      mem[s] = merge(mem[s], w0, b0);
      mem[s ^ 8'h01] = merge(mem[s ^ 8'h01], w1, b1);
      @(posedge core_clk);
    end
    else
    begin
      n = 0;
      do
      begin
        @(posedge core_clk);
        n++;
      end
      while (rdValid !== 1'b1 && n < 400);
      check(36'(rdValid), 36'h1);
      check(rdWord0, mem[s]);
      check(rdWord1, mem[s ^ 8'h01]);
    end
  endtask : send

  initial
  begin
    #1000000;
    miscompares++;
    final_report();
  end

  initial
  begin
    logic [1:0] j;
    logic [35:0] odtExp;
    void'($urandom(32'hAFD2D1B5));
    for (int c = 0; c < 3; c++)
    begin
      rstn <= 1'b0;
      orgSel <= dbs_pkg::dbs_org_e'(2'(2 - c));
      plusGen <= (c == 1);
      termOption <= (c == 1);
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      foreach (mem[i]) mem[i] = 36'h0;
      for (int t = 0; t < 3; t++)
      begin
        j = 2'(t);
        termLevel <= (j == 2'h1);
        termFloat <= (j == 2'h2);
        bypassReq <= j[0];
        repeat (16) @(posedge core_clk);
        check(36'(dllBypassed), 36'(j[0]));
        odtExp = (j == 2'h1 || (!termOption && j == 2'h2)) ? 36'h2 : (termOption ? 36'h0 : 36'h1);
        check(36'(odtMode), odtExp);
        check(36'({dbs_link_if_i.dqDevOe, dbs_link_if_i.dqHostOe}), 36'h0);
        check(36'({dbs_link_if_i.outClkTrue, dbs_link_if_i.outClkBar}), 36'h3);
      end
      send(1'b1, 8'h03, 36'hF0F0F0F0F, 36'h123456789, 4'h0, 4'h0);
      send(1'b0, 8'h03, 36'h0, 36'h0, 4'h0, 4'h0);
      send(1'b0, 8'h02, 36'h0, 36'h0, 4'h0, 4'h0);
      for (int k = 0; k < 30; k++)
      begin
        send(1'($urandom), 8'($urandom % 16), {4'($urandom), $urandom},
             {4'($urandom), $urandom}, 4'($urandom), 4'($urandom));
      end
    end
    final_report();
  end
endmodule : test_ddr_burst_sram_port
